// File: wdw_pkg.sv
// Purpose: shared constants and types of the window watchdog reset generator
// Assumes: 25 MHz system clock, all supply and pin levels arrive as logic levels
// Notes: every duration is given in its own unit and converted to cycles or ticks here

package wdw_pkg;

  // ---------------------------------------------------------------------------
  // clock and timebase
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 40;
  // sample period of the trigger pin with fast timing
  localparam int unsigned SAMPLE_PERIOD_NS = 250000;
  // least time, so rounded up
  localparam int unsigned SAMPLE_CYCLES = (SAMPLE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // slow timing stretches every watchdog and delay duration by this factor
  localparam int unsigned SLOW_FACTOR = 4;
  localparam int unsigned TICK_W = 16;

  // ---------------------------------------------------------------------------
  // supply glitch filter
  // ---------------------------------------------------------------------------
  localparam int unsigned REACTION_TIME_NS = 10000;
  localparam int unsigned RR_CYC_I = (REACTION_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [8:0] REACTION_CYCLES = 9'(RR_CYC_I);
  localparam logic [8:0] FILT_RESET = 9'h000;

  // ---------------------------------------------------------------------------
  // watchdog windows in sample ticks (fast timing figures)
  // ---------------------------------------------------------------------------
  localparam int unsigned RESET_DELAY_US = 8000;
  localparam int unsigned IGNORE_WINDOW_US = 32000;
  localparam int unsigned OPEN_WINDOW_US = 32000;
  localparam int unsigned CLOSED_WINDOW_US = 32000;
  localparam logic [7:0] DELAY_TICKS = 8'(RESET_DELAY_US * 1000 / SAMPLE_PERIOD_NS);
  localparam logic [7:0] IGNORE_TICKS = 8'(IGNORE_WINDOW_US * 1000 / SAMPLE_PERIOD_NS);
  localparam logic [7:0] OPEN_TICKS = 8'(OPEN_WINDOW_US * 1000 / SAMPLE_PERIOD_NS);
  localparam logic [7:0] CLOSED_TICKS = 8'(CLOSED_WINDOW_US * 1000 / SAMPLE_PERIOD_NS);
  localparam logic [7:0] CNT_RESET = 8'h00;

  // two high samples then two low samples, oldest in the top bit
  localparam logic [3:0] TRIG_PATTERN = 4'hC;
  localparam logic [3:0] SAMP_RESET = 4'h0;

  typedef enum logic [2:0] {
    ST_RESET    = 3'b000,
    ST_IGNORE   = 3'b001,
    ST_OPEN     = 3'b010,
    ST_CLOSED   = 3'b011,
    ST_DISABLED = 3'b100
  } wdw_state_t;

endpackage

// File: wdw_tick_gen.sv
// Purpose: sample tick generator dividing the system clock for the watchdog timebase
// Assumes: slow_i is already synchronised to clk_i
// Notes: tick_o is a one-cycle pulse every period or every SLOW_FACTOR periods

`timescale 1ns/1ps

module wdw_tick_gen #(
  parameter int unsigned CYCLES = wdw_pkg::SAMPLE_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic slow_i,
  output logic tick_o
);

  logic [wdw_pkg::TICK_W-1:0] div;
  logic [wdw_pkg::TICK_W-1:0] next_div;
  logic next_tick;
  logic [wdw_pkg::TICK_W-1:0] last;

  // ---------------------------------------------------------------------------
  // divider
  // ---------------------------------------------------------------------------
  // a switch of timing mode only moves the terminal count; a stale count above it wraps at once
  always_comb begin
    last = slow_i ? wdw_pkg::TICK_W'(CYCLES * wdw_pkg::SLOW_FACTOR - 1) :
                    wdw_pkg::TICK_W'(CYCLES - 1);
    next_tick = (div >= last);
    next_div = next_tick ? '0 : div + 16'h0001;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div <= 16'h0000;
      tick_o <= 1'b0;
    end else begin
      div <= next_div;
      tick_o <= next_tick;
    end
  end

endmodule

// File: wdw_reset_gen.sv
// Purpose: supply-fail reset and window watchdog driving the controller reset line
// Assumes: supply comparators, timing-select comparators and trigger pin are asynchronous
// Notes: all durations are counted in sample ticks except the supply glitch filter

`timescale 1ns/1ps

// Operation
// - either supply low longer than reaction time pulls reset low; shorter dips ignored
// - after low supply returns, hold reset for delay, release only if high supply good
// - timebase divides the clock; timing select chooses fast or slow rate
// - timing select low disables the watchdog, no watchdog resets at all; a window fault in the cycle the disable takes effect still resets
// - after power-on reset stays low for the reset delay, 8 ms fast
// - reset release starts a 32 ms ignore window, trigger pin disregarded
// - open window follows ignore; valid trigger starts closed window immediately
// - valid trigger inside closed window is a premature fault and asserts reset
// - closed window end starts open window, ending at trigger or after 32 ms
// - open window expiring without valid trigger asserts reset
// - trigger is two high then two low samples, sampled every 0.25 ms
// - trigger whose fourth sample lands in the open window is correct
module wdw_reset_gen #(
  parameter int unsigned SAMPLE_CYCLES = wdw_pkg::SAMPLE_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic high_supply_ok_i,
  input wire logic low_supply_ok_i,
  input wire logic timing_fast_i,
  input wire logic timing_off_i,
  input wire logic wd_trigger_in_i,
  output logic reset_out_n_o
);

  // ---------------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------------
  // bit order: high ok, low ok, fast, off, trigger
  logic [4:0] sync_a;
  logic [4:0] sync_b;
  logic hi_ok;
  logic lo_ok;
  logic fast;
  logic wd_off;
  logic trig_s;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_a <= 5'h00;
      sync_b <= 5'h00;
    end else begin
      sync_a <= {high_supply_ok_i, low_supply_ok_i, timing_fast_i, timing_off_i,
                 wd_trigger_in_i};
      sync_b <= sync_a;
    end
  end

  assign hi_ok = sync_b[4];
  assign lo_ok = sync_b[3];
  assign fast = sync_b[2];
  assign wd_off = sync_b[1];
  assign trig_s = sync_b[0];

  // ---------------------------------------------------------------------------
  // timebase
  // ---------------------------------------------------------------------------
  logic tick;

  wdw_tick_gen #(
    .CYCLES(SAMPLE_CYCLES)
  ) u_tick (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .slow_i(!fast),
    .tick_o(tick)
  );

  // ---------------------------------------------------------------------------
  // supply glitch filters
  // ---------------------------------------------------------------------------
  logic [8:0] hi_cnt;
  logic [8:0] lo_cnt;
  logic [8:0] next_hi_cnt;
  logic [8:0] next_lo_cnt;
  logic hi_fail;
  logic lo_fail;
  logic next_hi_fail;
  logic next_lo_fail;

  function automatic logic [8:0] filt_step(input logic ok, input logic [8:0] cnt);
    if (ok) begin
      filt_step = wdw_pkg::FILT_RESET;
    end else if (cnt == wdw_pkg::REACTION_CYCLES) begin
      filt_step = cnt;
    end else begin
      filt_step = cnt + 9'h001;
    end
  endfunction

  // a dip must outlast the reaction time before it counts, so short glitches vanish
  always_comb begin
    next_hi_cnt = filt_step(hi_ok, hi_cnt);
    next_lo_cnt = filt_step(lo_ok, lo_cnt);
    next_hi_fail = !hi_ok && (hi_cnt == wdw_pkg::REACTION_CYCLES);
    next_lo_fail = !lo_ok && (lo_cnt == wdw_pkg::REACTION_CYCLES);
  end

  // both supplies count as failed only for the first clock after reset
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hi_cnt <= wdw_pkg::FILT_RESET;
      lo_cnt <= wdw_pkg::FILT_RESET;
      hi_fail <= 1'b1;
      lo_fail <= 1'b1;
    end else begin
      hi_cnt <= next_hi_cnt;
      lo_cnt <= next_lo_cnt;
      hi_fail <= next_hi_fail;
      lo_fail <= next_lo_fail;
    end
  end

  // ---------------------------------------------------------------------------
  // trigger sampler
  // ---------------------------------------------------------------------------
  logic [3:0] samp;
  logic [3:0] next_samp;
  logic trig_valid;

  // sampling runs in every state so a pulse straddling a window edge is judged whole
  always_comb begin
    next_samp = tick ? {samp[2:0], trig_s} : samp;
    trig_valid = tick && ({samp[2:0], trig_s} == wdw_pkg::TRIG_PATTERN);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      samp <= wdw_pkg::SAMP_RESET;
    end else begin
      samp <= next_samp;
    end
  end

  // ---------------------------------------------------------------------------
  // window state machine
  // ---------------------------------------------------------------------------
  wdw_pkg::wdw_state_t state;
  wdw_pkg::wdw_state_t next_state;
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic [7:0] cnt_inc;
  logic next_reset_n;

  always_comb begin
    next_state = state;
    cnt_inc = tick ? cnt + 8'h01 : cnt;
    next_cnt = cnt_inc;
    case (state)
      wdw_pkg::ST_RESET: begin
        // delay runs only while the low supply is good
        if (lo_fail) begin
          next_cnt = wdw_pkg::CNT_RESET;
        end else if (cnt >= wdw_pkg::DELAY_TICKS) begin
          next_cnt = wdw_pkg::DELAY_TICKS;
          if (!hi_fail) begin
            next_state = wd_off ? wdw_pkg::ST_DISABLED : wdw_pkg::ST_IGNORE;
            next_cnt = wdw_pkg::CNT_RESET;
          end
        end
      end
      wdw_pkg::ST_IGNORE: begin
        // trigger results are dropped here
        if (tick && cnt == wdw_pkg::IGNORE_TICKS - 8'h01) begin
          next_state = wdw_pkg::ST_OPEN;
          next_cnt = wdw_pkg::CNT_RESET;
        end
      end
      wdw_pkg::ST_OPEN: begin
        if (trig_valid) begin
          next_state = wdw_pkg::ST_CLOSED;
          next_cnt = wdw_pkg::CNT_RESET;
        end else if (tick && cnt == wdw_pkg::OPEN_TICKS - 8'h01) begin
          next_state = wdw_pkg::ST_RESET;
          next_cnt = wdw_pkg::CNT_RESET;
        end
      end
      wdw_pkg::ST_CLOSED: begin
        if (trig_valid) begin
          next_state = wdw_pkg::ST_RESET;
          next_cnt = wdw_pkg::CNT_RESET;
        end else if (tick && cnt == wdw_pkg::CLOSED_TICKS - 8'h01) begin
          next_state = wdw_pkg::ST_OPEN;
          next_cnt = wdw_pkg::CNT_RESET;
        end
      end
      wdw_pkg::ST_DISABLED: begin
        next_cnt = wdw_pkg::CNT_RESET;
        if (!wd_off) begin
          next_state = wdw_pkg::ST_IGNORE;
        end
      end
      default: begin
        next_state = wdw_pkg::ST_RESET;
        next_cnt = wdw_pkg::CNT_RESET;
      end
    endcase
    // turning the watchdog off stops it in any running window, unless a window fault resets it in that same cycle
    if (wd_off && next_state != wdw_pkg::ST_RESET && state != wdw_pkg::ST_RESET) begin
      next_state = wdw_pkg::ST_DISABLED;
      next_cnt = wdw_pkg::CNT_RESET;
    end
    // a supply failure overrides everything and restarts the delay, except a high-supply failure while already in ST_RESET
    if (hi_fail || lo_fail) begin
      next_state = wdw_pkg::ST_RESET;
      if (state != wdw_pkg::ST_RESET) begin
        next_cnt = wdw_pkg::CNT_RESET;
      end
    end
    next_reset_n = (next_state != wdw_pkg::ST_RESET);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= wdw_pkg::ST_RESET;
      cnt <= wdw_pkg::CNT_RESET;
      reset_out_n_o <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      reset_out_n_o <= next_reset_n;
    end
  end

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  // helper: cycles since the last tick, and whether fast timing held since that tick;
  // a mode switch between two ticks moves the terminal count, so that gap is not judged
  logic [15:0] gap;
  logic gap_ok;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gap <= 16'h0000;
      gap_ok <= 1'b0;
    end else begin
      gap <= tick ? 16'h0000 : gap + 16'h0001;
      gap_ok <= tick ? fast : (gap_ok && fast);
    end
  end

  supply_fail_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (hi_fail || lo_fail) |=> !reset_out_n_o)
    else $error("supply failure did not hold reset low");

  release_hi_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(reset_out_n_o) |-> !$past(hi_fail) && !$past(lo_fail))
    else $error("reset released with a supply below threshold");

  tick_period_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (tick && gap_ok && fast) |-> gap == 16'(SAMPLE_CYCLES - 1))
    else $error("fast timebase period wrong");

  wd_off_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state == wdw_pkg::ST_DISABLED && !hi_fail && !lo_fail) |=> reset_out_n_o)
    else $error("reset asserted while watchdog disabled");

  delay_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(reset_out_n_o) |-> $past(cnt) == wdw_pkg::DELAY_TICKS)
    else $error("reset released before the delay ran out");

  ignore_start_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ($rose(reset_out_n_o) && !$past(wd_off)) |-> state == wdw_pkg::ST_IGNORE && cnt == 8'h00)
    else $error("ignore window not started at reset release");

  closed_start_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state == wdw_pkg::ST_OPEN && trig_valid && !hi_fail && !lo_fail && !wd_off)
    |=> state == wdw_pkg::ST_CLOSED ##1 reset_out_n_o)
    else $error("valid trigger in open window did not start closed window");

  pretrigger_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state == wdw_pkg::ST_CLOSED && trig_valid) |=> !reset_out_n_o)
    else $error("premature trigger did not reset");

  reopen_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state == wdw_pkg::ST_CLOSED && tick && cnt == wdw_pkg::CLOSED_TICKS - 8'h01 &&
     !trig_valid && !hi_fail && !lo_fail && !wd_off) |=> state == wdw_pkg::ST_OPEN)
    else $error("open window not restarted after closed window");

  timeout_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state == wdw_pkg::ST_OPEN && tick && cnt == wdw_pkg::OPEN_TICKS - 8'h01 && !trig_valid)
    |=> !reset_out_n_o)
    else $error("open window timeout did not reset");

  trig_shape_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    trig_valid |-> tick && !trig_s && samp[2:0] == 3'b110)
    else $error("trigger accepted without two high then two low samples");

endmodule

// File: wdw_mcu_model.sv
// Purpose: behavioural controller that services the watchdog trigger pin
// Assumes: times count clk_i cycles from the moment the reset line is high and run_i is set
// Notes: pin idles high in reset or when quiet; spacing is chosen by the bench only

`timescale 1ns/1ps

module wdw_mcu_model (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic run_i,
  input wire logic [15:0] first_i,
  input wire logic [15:0] period_i,
  output logic trig_o
);
  // ---------------------------------------------------------------------------
  // trigger pattern
  // ---------------------------------------------------------------------------
  logic [15:0] cnt;
  logic [15:0] phase;

  // cycles since the controller left reset with servicing switched on
  always_ff @(posedge clk_i) begin
    if (!reset_n_i || !run_i) begin
      cnt <= 16'h0000;
    end else begin
      cnt <= cnt + 16'h0001;
    end
  end

  // falling edge each period; both halves last far longer than two samples
  always_comb begin
    phase = (cnt - first_i) % period_i;
    trig_o = !(reset_n_i && run_i && cnt >= first_i && phase < (period_i >> 1));
  end
endmodule

// File: wdw_tb.sv
// Purpose: self-checking bench of the window watchdog reset generator
// Assumes: SAMPLE_CYCLES of 4, so a tick is 4 clocks fast and 16 clocks slow
// Notes: every reset edge is matched to the oldest note of a cycle window

`timescale 1ns/1ps

module testbench;
  // ---------------------------------------------------------------------------
  // stimulus, design and far side
  // ---------------------------------------------------------------------------
  typedef struct {logic lvl; longint lo; longint hi;} wdw_note_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hi_ok = 1'b1;
  logic lo_ok = 1'b1;
  logic fast = 1'b1;
  logic off = 1'b0;
  logic run = 1'b0;
  logic [15:0] first = 16'h02A0;
  logic [15:0] period = 16'h021C;
  logic [15:0] rnd = 16'h004D;
  logic trig;
  logic rst_out_n;
  logic prev = 1'b0;
  longint cyc = 0;
  int n_mismatch = 0;
  int tests_run = 0;
  wdw_note_t q[$];

  always #20 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  wdw_reset_gen #(.SAMPLE_CYCLES(4)) i_dut (
    .clk_i(clk), .rst_n_i(rst_n), .high_supply_ok_i(hi_ok), .low_supply_ok_i(lo_ok),
    .timing_fast_i(fast), .timing_off_i(off), .wd_trigger_in_i(trig),
    .reset_out_n_o(rst_out_n));

  wdw_mcu_model i_mcu (
    .clk_i(clk), .reset_n_i(rst_out_n), .run_i(run), .first_i(first),
    .period_i(period), .trig_o(trig));

  // ---------------------------------------------------------------------------
  // checking helpers
  // ---------------------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  task automatic fail(input string msg);
    n_mismatch++;
    $display("CHECK FAILED at %0t: %s", $time, msg);
  endtask

  task automatic cmp_edge(input logic got, input wdw_note_t n);
    tests_run++;
    if (got !== n.lvl || cyc < n.lo || cyc > n.hi) begin
      fail($sformatf("reset %b at cycle %0d, want %b in %0d..%0d", got, cyc, n.lvl, n.lo, n.hi));
    end
  endtask

  // expected edge level and its cycle window, relative to now
  task automatic note(input logic lvl, input int lo, input int hi);
    wdw_note_t n;
    n.lvl = lvl;
    n.lo = cyc + lo;
    n.hi = cyc + hi;
    q.push_back(n);
  endtask

  task automatic drain();
    while (q.size() != 0) @(posedge clk);
    @(posedge clk);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic print_verdict();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // watcher: any edge of the reset line must match the oldest note
  always @(posedge clk) begin
    if (rst_n) begin
      if (rst_out_n !== prev) begin
        if (q.size() == 0) fail("unexpected reset edge");
        else cmp_edge(rst_out_n, q.pop_front());
      end else if (q.size() != 0 && cyc > q[0].hi) begin
        fail("expected reset edge missing");
        void'(q.pop_front());
      end
    end
    prev <= rst_out_n;
  end

  // hang guard, well above the longest expected run
  always @(posedge clk) begin
    if (cyc == 40000) begin
      fail("run timed out");
      print_verdict();
    end
  end

  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  initial begin
    int p;
    idle(3);
    rst_n <= 1'b1;
    note(1'b1, 125, 150);
    drain();
    // pin toggles only inside the ignore window, so service never counts
    first <= 16'h0010;
    period <= 16'h0100;
    run <= 1'b1;
    note(1'b0, 1010, 1045);
    idle(400);
    run <= 1'b0;
    drain();
    note(1'b1, 120, 150);
    drain();
    // random spacing that always lands in the open window, then abandoned
    first <= 16'h02A0;
    repeat (2) begin
      rnd = lfsr(rnd);
      p = 540 + int'(rnd % 16'h0168);
      period <= 16'(p);
      run <= 1'b1;
      idle(672 + 4 * p + p / 4);
      run <= 1'b0;
      note(1'b0, 1024 - p / 4, 1046 - p / 4);
      drain();
      note(1'b1, 120, 150);
      drain();
    end
    // second trigger falls inside the closed window
    period <= 16'h0100;
    run <= 1'b1;
    note(1'b0, 920, 965);
    drain();
    run <= 1'b0;
    note(1'b1, 120, 150);
    drain();
    // disabled watchdog must stay silent; release restarts the ignore window
    off <= 1'b1;
    idle(3000);
    off <= 1'b0;
    note(1'b0, 1010, 1045);
    drain();
    note(1'b1, 120, 150);
    drain();
    // short dip is a glitch, a long one resets
    lo_ok <= 1'b0;
    idle(200);
    lo_ok <= 1'b1;
    idle(300);
    lo_ok <= 1'b0;
    note(1'b0, 250, 262);
    drain();
    idle(100);
    lo_ok <= 1'b1;
    note(1'b1, 125, 150);
    drain();
    // high supply alone holds reset past the delay
    hi_ok <= 1'b0;
    note(1'b0, 250, 262);
    drain();
    idle(600);
    hi_ok <= 1'b1;
    note(1'b1, 2, 12);
    drain();
    // slow timing stretches windows and delay fourfold
    fast <= 1'b0;
    note(1'b0, 4070, 4130);
    drain();
    note(1'b1, 505, 545);
    drain();
    print_verdict();
  end
endmodule
